// ==== hw/rftx_pkg.sv ====
// Constants and carrier types of the antenna driver control register bank.
// Assumes one core clock; the bank is reached over APB with one word per register.
package rftx_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_COMMAND = 6'h01;
    localparam logic [5:0] IDX_STATUS = 6'h02;
    localparam logic [5:0] IDX_RX_MODE = 6'h13;
    localparam logic [5:0] IDX_DRV_CTRL = 6'h14;
    localparam logic [5:0] IDX_KEYING = 6'h15;
    localparam logic [5:0] IDX_SRC_SEL = 6'h16;

    // Reset values
    localparam logic [7:0] RST_RX_MODE = 8'h00;
    localparam logic [7:0] RST_DRV_CTRL = 8'h80;
    localparam logic [7:0] RST_KEYING = 8'h00;
    localparam logic [7:0] RST_SRC_SEL = 8'h10;
    localparam logic [3:0] RST_COMMAND = 4'h0;

    // Writable bits; the rest read as zero
    localparam logic [7:0] MSK_RX_MODE = 8'hfc;
    localparam logic [7:0] MSK_DRV_CTRL = 8'hfb;
    localparam logic [7:0] MSK_KEYING = 8'h40;
    localparam logic [7:0] MSK_SRC_SEL = 8'h3f;

    // Field positions
    localparam int POS_MULTI_FRAME = 2;
    localparam int POS_INV_ON = 6;
    localparam int POS_INV_OFF = 4;
    localparam int POS_CW = 3;
    localparam int POS_FULL_DEPTH = 6;
    localparam int POS_DRV_SRC = 4;
    localparam int POS_ERR_CRC = 2;

    // Command codes
    localparam logic [3:0] CMD_RECEIVE = 4'h8;
    localparam logic [3:0] CMD_TRANSCEIVE = 4'hc;

    typedef enum logic [0:0] {
        RX_OFF = 1'b0,
        RX_ON = 1'b1
    } rftx_rx_e;

    typedef enum logic [1:0] {
        DSRC_TRISTATE = 2'b00,
        DSRC_MILLER = 2'b01,
        DSRC_AUX_IN = 2'b10,
        DSRC_HIGH = 2'b11
    } rftx_dsrc_e;

    typedef enum logic [3:0] {
        AUX_TRISTATE = 4'b0000,
        AUX_LOW = 4'b0001,
        AUX_HIGH = 4'b0010,
        AUX_TEST_BUS = 4'b0011,
        AUX_MILLER = 4'b0100,
        AUX_TX_SERIAL = 4'b0101,
        AUX_RX_SERIAL = 4'b0111
    } rftx_aux_e;

    // Output pin with its enable
    typedef struct packed {
        logic o;
        logic oe;
    } rftx_pin_s;

endpackage

// ==== hw/rftx_regs.sv ====
// Antenna driver control register bank with multi-frame receive control.
// Assumes synchronous inputs on core_clk, an APB master, and a one-cycle frame_end pulse.
`timescale 1ns/100ps

// Operation
// - Multi-frame bit clear: receiver switches off after one received frame.
// - Multi-frame bit set: receiver keeps accepting frames; software uses it above 106 kBd.
// - With multi-frame, receive commands end only on other command or bit clear.
// - With multi-frame, an error register copy byte is pushed after each frame.
// - Error byte CRC bit: checksum-ok on version two, checksum-error on version one.
// - Bits 7 and 6 invert driver two and one while enabled.
// - Bits 5 and 4 invert driver two and one while disabled.
// - Bit 3 makes driver two output unmodulated carrier continuously.
// - Bits 1 and 0 enable drivers two and one with modulated carrier.
// - Keying bit 6 forces full-depth keying regardless of conductance setting.
// - Source tristate makes both drivers high impedance, also in power-down.
// - Source 01 Miller envelope, 10 auxiliary input, 11 constant high, inverted only where the inversion bit is set.
// - Driver control register resets to 80h.
// - Source select register resets to 10h.
// - Auxiliary output select drives aux pin per code; reserved codes tristate.
module rftx_regs
    import rftx_pkg::*;
#(
    parameter logic VERSION_TWO = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic carrier_in,
    input wire logic miller_envelope,
    input wire logic aux_envelope_input,
    input wire logic test_bus_bit,
    input wire logic tx_serial_data,
    input wire logic rx_serial_data,
    input wire logic frame_end,
    input wire logic [7:0] error_register,
    input wire logic checksum_ok_flag,
    input wire logic checksum_error_flag,
    output rftx_pin_s antenna_driver_one,
    output rftx_pin_s antenna_driver_two,
    output rftx_pin_s aux_output_pin,
    output logic receiver_active,
    output logic force_full_depth_keying,
    output logic [1:0] drv_keying_pause,
    output logic fifo_push,
    output logic [7:0] fifo_data
);

    logic [7:0] rx_mode_ff;
    logic [7:0] drv_ctrl_ff;
    logic [7:0] keying_ff;
    logic [7:0] src_sel_ff;
    logic [3:0] command_ff;
    rftx_rx_e rx_state_ff;
    rftx_rx_e nxt_rx_state;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic fifo_push_ff;
    logic [7:0] fifo_data_ff;
    rftx_pin_s drv_pin_ff [2];
    rftx_pin_s nxt_drv_pin [2];
    logic pause_ff [2];
    logic nxt_pause [2];
    rftx_pin_s aux_pin_ff;
    rftx_pin_s nxt_aux_pin;
    logic apb_access;
    logic apb_wr;
    logic [5:0] idx;
    logic [7:0] wbyte;
    logic wr_command;
    logic wr_rx_mode;
    logic multi_frame_receive;
    logic [7:0] err_byte;
    rftx_dsrc_e driver_source_select;
    rftx_aux_e aux_output_select;

    function automatic logic idx_mapped(input logic [5:0] i);
        idx_mapped = (i == IDX_COMMAND) || (i == IDX_STATUS) || (i == IDX_RX_MODE) ||
                     (i == IDX_DRV_CTRL) || (i == IDX_KEYING) || (i == IDX_SRC_SEL);
    endfunction

    function automatic logic cmd_receives(input logic [3:0] c);
        cmd_receives = (c == CMD_RECEIVE) || (c == CMD_TRANSCEIVE);
    endfunction

    assign idx = paddr[7:2];
    assign wbyte = pwdata[7:0];
    assign apb_access = psel && penable && pready_ff;
    assign apb_wr = apb_access && pwrite && idx_mapped(idx);
    assign wr_command = apb_wr && (idx == IDX_COMMAND);
    assign wr_rx_mode = apb_wr && (idx == IDX_RX_MODE);
    assign multi_frame_receive = rx_mode_ff[POS_MULTI_FRAME];
    assign driver_source_select = rftx_dsrc_e'(src_sel_ff[POS_DRV_SRC +: 2]);
    assign aux_output_select = rftx_aux_e'(src_sel_ff[3:0]);

    // APB handshake: answer in the cycle after setup
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && !penable && !pready_ff;
            pslverr_ff <= psel && !penable && !pready_ff && !idx_mapped(paddr[7:2]);
        end
    end

    // Read data, reserved bits zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr[7:2])
                IDX_COMMAND: prdata_ff <= {28'h0, command_ff};
                IDX_STATUS: prdata_ff <= {30'h0, multi_frame_receive, rx_state_ff == RX_ON};
                IDX_RX_MODE: prdata_ff <= {24'h0, rx_mode_ff & MSK_RX_MODE};
                IDX_DRV_CTRL: prdata_ff <= {24'h0, drv_ctrl_ff & MSK_DRV_CTRL};
                IDX_KEYING: prdata_ff <= {24'h0, keying_ff & MSK_KEYING};
                IDX_SRC_SEL: prdata_ff <= {24'h0, src_sel_ff & MSK_SRC_SEL};
                default: prdata_ff <= 32'h0;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_mode_ff <= RST_RX_MODE;
            drv_ctrl_ff <= RST_DRV_CTRL;
            keying_ff <= RST_KEYING;
            src_sel_ff <= RST_SRC_SEL;
        end else if (apb_wr) begin
            unique case (idx)
                IDX_RX_MODE: rx_mode_ff <= wbyte & MSK_RX_MODE;
                IDX_DRV_CTRL: drv_ctrl_ff <= wbyte & MSK_DRV_CTRL;
                IDX_KEYING: keying_ff <= wbyte & MSK_KEYING;
                IDX_SRC_SEL: src_sel_ff <= wbyte & MSK_SRC_SEL;
                default: ;
            endcase
        end
    end

    // Command register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            command_ff <= RST_COMMAND;
        end else if (wr_command) begin
            command_ff <= wbyte[3:0];
        end
    end

    // Receiver on/off control
    always_comb begin
        nxt_rx_state = rx_state_ff;
        if (wr_command) begin
            // Any other command ends reception
            nxt_rx_state = cmd_receives(wbyte[3:0]) ? RX_ON : RX_OFF;
        end else if (wr_rx_mode && !wbyte[POS_MULTI_FRAME] && multi_frame_receive) begin
            nxt_rx_state = RX_OFF;
        end else if (rx_state_ff == RX_ON && frame_end && !multi_frame_receive) begin
            nxt_rx_state = RX_OFF;
        end
        // Multi-frame keeps the receiver on across frames
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_state_ff <= RX_OFF;
        end else begin
            rx_state_ff <= nxt_rx_state;
        end
    end

    // Error byte with version-dependent CRC flag
    always_comb begin
        err_byte = error_register;
        err_byte[POS_ERR_CRC] = VERSION_TWO ? checksum_ok_flag : checksum_error_flag;
    end

    // Append error byte after each frame in multi-frame mode
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fifo_push_ff <= 1'b0;
            fifo_data_ff <= 8'h00;
        end else begin
            fifo_push_ff <= (rx_state_ff == RX_ON) && frame_end && multi_frame_receive;
            if ((rx_state_ff == RX_ON) && frame_end && multi_frame_receive) begin
                fifo_data_ff <= err_byte;
            end
        end
    end

    // Antenna drivers
    for (genvar i = 0; i < 2; i++) begin : g_drv
        logic en;
        logic inv;
        logic cw;
        logic env;
        logic raw;

        assign en = drv_ctrl_ff[i];
        // On-state and off-state inversion
        assign inv = en ? drv_ctrl_ff[POS_INV_ON + i] : drv_ctrl_ff[POS_INV_OFF + i];
        assign cw = (i == 1) && drv_ctrl_ff[POS_CW];
        // Envelope source, active low
        assign env = (driver_source_select == DSRC_AUX_IN) ? aux_envelope_input :
                     miller_envelope;

        always_comb begin
            raw = 1'b0;
            nxt_pause[i] = 1'b0;
            nxt_drv_pin[i].oe = 1'b1;
            if (driver_source_select == DSRC_TRISTATE) begin
                nxt_drv_pin[i].oe = 1'b0;
            end else if (driver_source_select == DSRC_HIGH) begin
                raw = 1'b1;
            end else if (en && cw) begin
                raw = carrier_in;
            end else if (en) begin
                nxt_pause[i] = !env;
                // Full-depth keying blanks the carrier in pauses
                raw = carrier_in && (env || !keying_ff[POS_FULL_DEPTH]);
            end
            nxt_drv_pin[i].o = nxt_drv_pin[i].oe && (raw ^ inv);
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                drv_pin_ff[i] <= '0;
                pause_ff[i] <= 1'b0;
            end else begin
                drv_pin_ff[i] <= nxt_drv_pin[i];
                pause_ff[i] <= nxt_pause[i];
            end
        end
    end

    // Auxiliary output mux; reserved codes tristate
    always_comb begin
        nxt_aux_pin.oe = 1'b1;
        nxt_aux_pin.o = 1'b0;
        unique case (aux_output_select)
            AUX_LOW: nxt_aux_pin.o = 1'b0;
            AUX_HIGH: nxt_aux_pin.o = 1'b1;
            AUX_TEST_BUS: nxt_aux_pin.o = test_bus_bit;
            AUX_MILLER: nxt_aux_pin.o = miller_envelope;
            AUX_TX_SERIAL: nxt_aux_pin.o = tx_serial_data;
            AUX_RX_SERIAL: nxt_aux_pin.o = rx_serial_data;
            default: nxt_aux_pin.oe = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aux_pin_ff <= '0;
        end else begin
            aux_pin_ff <= nxt_aux_pin;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign antenna_driver_one = drv_pin_ff[0];
    assign antenna_driver_two = drv_pin_ff[1];
    assign aux_output_pin = aux_pin_ff;
    assign receiver_active = (rx_state_ff == RX_ON);
    assign force_full_depth_keying = keying_ff[POS_FULL_DEPTH];
    assign drv_keying_pause = {pause_ff[1], pause_ff[0]};
    assign fifo_push = fifo_push_ff;
    assign fifo_data = fifo_data_ff;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_frame_single;
        receiver_active && frame_end && !multi_frame_receive && !wr_command;
    endsequence

    sequence s_frame_multi;
        receiver_active && frame_end && multi_frame_receive && !wr_command && !wr_rx_mode;
    endsequence

    chk_single_frame_off: assert property (s_frame_single |=> !receiver_active)
        else $error("Receiver stayed on after a single frame");
    chk_multi_stays_on: assert property (s_frame_multi |=> receiver_active)
        else $error("Receiver stopped in multi-frame mode");
    chk_cmd_stops: assert property (wr_command && !cmd_receives(wbyte[3:0])
        |=> !receiver_active)
        else $error("Other command did not end reception");
    chk_clear_stops: assert property (wr_rx_mode && !wbyte[POS_MULTI_FRAME]
        && multi_frame_receive |=> !receiver_active)
        else $error("Clearing multi-frame did not end reception");
    chk_error_byte_push: assert property (s_frame_multi |=> fifo_push
        && fifo_data[7:3] == $past(error_register[7:3])
        && fifo_data[1:0] == $past(error_register[1:0]))
        else $error("Error byte not appended");
    chk_crc_flag_ver: assert property (fifo_push |-> fifo_data[POS_ERR_CRC] ==
        (VERSION_TWO ? $past(checksum_ok_flag) : $past(checksum_error_flag)))
        else $error("Wrong CRC flag in error byte");
    chk_no_push_single: assert property (s_frame_single |=> !fifo_push)
        else $error("Error byte pushed in single-frame mode");
    chk_inv_on_high: assert property (driver_source_select == DSRC_HIGH
        && drv_ctrl_ff[0]
        |=> antenna_driver_one.oe && antenna_driver_one.o == !$past(drv_ctrl_ff[POS_INV_ON]))
        else $error("Driver one on-state inversion wrong");
    chk_inv_off_high: assert property (driver_source_select == DSRC_HIGH
        && !drv_ctrl_ff[1] |=> antenna_driver_two.o == !$past(drv_ctrl_ff[POS_INV_OFF + 1]))
        else $error("Driver two off-state inversion wrong");
    chk_cw_carrier: assert property (driver_source_select == DSRC_MILLER
        && drv_ctrl_ff[1] && drv_ctrl_ff[POS_CW] |=> antenna_driver_two.o ==
        ($past(carrier_in) ^ $past(drv_ctrl_ff[POS_INV_ON + 1])))
        else $error("Driver two continuous wave wrong");
    chk_drv_carrier: assert property (driver_source_select == DSRC_MILLER
        && drv_ctrl_ff[0] && miller_envelope |=> antenna_driver_one.o ==
        ($past(carrier_in) ^ $past(drv_ctrl_ff[POS_INV_ON])))
        else $error("Driver one carrier not passed");
    chk_force_depth: assert property (driver_source_select == DSRC_MILLER
        && drv_ctrl_ff[0] && keying_ff[POS_FULL_DEPTH] && !miller_envelope
        |=> antenna_driver_one.o == $past(drv_ctrl_ff[POS_INV_ON]))
        else $error("Full-depth keying did not blank carrier");
    chk_drv_tristate: assert property (driver_source_select == DSRC_TRISTATE
        |=> !antenna_driver_one.oe && !antenna_driver_two.oe)
        else $error("Drivers not tristated");
    chk_reset_values: assert property ($rose(rst_n)
        |-> drv_ctrl_ff == RST_DRV_CTRL && src_sel_ff == RST_SRC_SEL)
        else $error("Wrong reset value");
    chk_aux_low: assert property (aux_output_select == AUX_LOW
        |=> aux_output_pin.oe && !aux_output_pin.o)
        else $error("Aux pin not low");
    chk_reserved_zero: assert property (psel && !penable && !pwrite
        && paddr[7:2] == IDX_DRV_CTRL |=> prdata[2] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("Reserved bits read nonzero");

endmodule

// ==== tb/rftx_field_model.sv ====
// Model of the antenna stage and card field facing the driver outputs.
// Assumes the bench sets carrier level and envelope pauses between checks.
`timescale 1ns/100ps
module rftx_field_model
    import rftx_pkg::*;
(
    input wire logic carrier_level,
    input wire logic env_pause,
    input wire logic aux_pause,
    input wire rftx_pin_s antenna_driver_one,
    input wire rftx_pin_s antenna_driver_two,
    output logic carrier_in,
    output logic miller_envelope,
    output logic aux_envelope_input,
    output logic field_on
);
    assign carrier_in = carrier_level;
    // Envelopes are active low: 0 means pause
    assign miller_envelope = ~env_pause;
    assign aux_envelope_input = ~aux_pause;
    assign field_on = (antenna_driver_one.oe & antenna_driver_one.o)
        | (antenna_driver_two.oe & antenna_driver_two.o);
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the antenna driver control register bank.
// Assumes APB access with one byte per word and the field model on the driver side.
`timescale 1ns/100ps
module testbench;
    import rftx_pkg::*;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, error_register = 0;
    logic [31:0] pwdata = 0, prdata, rd_data;
    logic pready, pslverr, rd_err, frame_end = 0, ck_ok = 0, ck_err = 0;
    logic car_lvl = 1, env_pause = 0, aux_pause = 0, carrier_in, miller_env, aux_env;
    logic receiver_active, force_full_depth_keying, fifo_push, field_on;
    logic [1:0] drv_keying_pause;
    logic [7:0] fifo_data;
    rftx_pin_s drv1, drv2, aux;
    int err_total = 0, checks = 0, cyc = 0;
    logic [1:0] srcs [3] = '{2'b01, 2'b11, 2'b00};
    logic [7:0] ctls [6] = '{8'h00, 8'h03, 8'hc3, 8'h33, 8'hf0, 8'h52};
    logic [1:0] aux_exp [9] = '{2'b00, 2'b01, 2'b11, 2'b11, 2'b11, 2'b01, 2'b00, 2'b11, 2'b00};
    logic tbus = 1, txs = 0, rxs = 1;
    logic [7:0] cv;
    logic [1:0] e1, e2;

    always #5 core_clk = ~core_clk;

    rftx_regs u_rftx_regs (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .carrier_in(carrier_in),
        .miller_envelope(miller_env), .aux_envelope_input(aux_env),
        .test_bus_bit(tbus), .tx_serial_data(txs), .rx_serial_data(rxs),
        .frame_end(frame_end), .error_register(error_register),
        .checksum_ok_flag(ck_ok), .checksum_error_flag(ck_err),
        .antenna_driver_one(drv1), .antenna_driver_two(drv2), .aux_output_pin(aux),
        .receiver_active(receiver_active), .force_full_depth_keying(force_full_depth_keying),
        .drv_keying_pause(drv_keying_pause), .fifo_push(fifo_push), .fifo_data(fifo_data));

    rftx_field_model u_rftx_field_model (.carrier_level(car_lvl), .env_pause(env_pause),
        .aux_pause(aux_pause), .antenna_driver_one(drv1), .antenna_driver_two(drv2),
        .carrier_in(carrier_in), .miller_envelope(miller_env),
        .aux_envelope_input(aux_env), .field_on(field_on));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic eerr);
        xfer(1'b0, idx, 8'h00);
        chk(rd_data, {24'h0, exp});
        chk({31'h0, rd_err}, {31'h0, eerr});
    endtask

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic frame();
        @(posedge core_clk);
        frame_end <= 1'b1;
        @(posedge core_clk);
        frame_end <= 1'b0;
        #1;
    endtask

    function automatic logic [1:0] pv(input rftx_pin_s p);
        return {p.o & p.oe, p.oe};
    endfunction

    function automatic logic [1:0] exp_pin(input logic [1:0] s, input logic car,
        input logic en, input logic inv_on, input logic inv_off);
        logic raw;
        if (s == 2'b00) return 2'b00;
        raw = (s == 2'b11) ? 1'b1 : (en & car);
        return {raw ^ (en ? inv_on : inv_off), 1'b1};
    endfunction

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(IDX_DRV_CTRL, 8'h80, 1'b0);
        rd(IDX_SRC_SEL, 8'h10, 1'b0);
        rd(IDX_KEYING, 8'h00, 1'b0);
        rd(6'h3f, 8'h00, 1'b1);
        xfer(1'b1, IDX_KEYING, 8'hff);
        rd(IDX_KEYING, 8'h40, 1'b0);
        chk({31'h0, force_full_depth_keying}, 32'h1);
        xfer(1'b1, IDX_SRC_SEL, 8'hff);
        rd(IDX_SRC_SEL, 8'h3f, 1'b0);
        xfer(1'b1, IDX_DRV_CTRL, 8'hff);
        rd(IDX_DRV_CTRL, 8'hfb, 1'b0);
        xfer(1'b1, IDX_KEYING, 8'h00);
        settle();
        chk({31'h0, force_full_depth_keying}, 32'h0);
        // Driver output across sources, carrier levels and control values
        for (int s = 0; s < 3; s++) begin
            xfer(1'b1, IDX_SRC_SEL, {2'b00, srcs[s], 4'h0});
            for (int k = 0; k < 12; k++) begin
                car_lvl <= k[0];
                cv = ctls[k / 2];
                xfer(1'b1, IDX_DRV_CTRL, cv);
                settle();
                e1 = exp_pin(srcs[s], k[0], cv[0], cv[6], cv[4]);
                e2 = exp_pin(srcs[s], k[0], cv[1], cv[7], cv[5]);
                chk(pv(drv1), e1);
                chk(pv(drv2), e2);
            end
        end
        // Pauses reach enabled drivers; continuous wave keeps driver two unmodulated
        car_lvl <= 1'b1;
        env_pause <= 1'b1;
        xfer(1'b1, IDX_SRC_SEL, 8'h10);
        xfer(1'b1, IDX_DRV_CTRL, 8'h03);
        settle();
        chk({30'h0, drv_keying_pause}, 32'h3);
        chk(pv(drv1), 32'h3);
        chk({31'h0, field_on}, 32'h1);
        // Full-depth keying blanks both carriers during the pause
        xfer(1'b1, IDX_KEYING, 8'h40);
        settle();
        chk(pv(drv1), 32'h1);
        chk({31'h0, field_on}, 32'h0);
        xfer(1'b1, IDX_KEYING, 8'h00);
        xfer(1'b1, IDX_DRV_CTRL, 8'h0b);
        settle();
        chk({30'h0, drv_keying_pause}, 32'h1);
        chk(pv(drv2), 32'h3);
        // Auxiliary envelope source ignores the internal pause
        xfer(1'b1, IDX_DRV_CTRL, 8'h03);
        xfer(1'b1, IDX_SRC_SEL, 8'h20);
        settle();
        chk({30'h0, drv_keying_pause}, 32'h0);
        aux_pause <= 1'b1;
        env_pause <= 1'b0;
        settle();
        chk({30'h0, drv_keying_pause}, 32'h3);
        aux_pause <= 1'b0;
        // Aux output codes 0 to 8, reserved codes 6 and 8 included
        for (int c = 0; c < 9; c++) begin
            xfer(1'b1, IDX_SRC_SEL, 8'h10 | c[7:0]);
            settle();
            chk(pv(aux), aux_exp[c]);
        end
        // Single-frame reception
        xfer(1'b1, IDX_COMMAND, {4'h0, CMD_RECEIVE});
        settle();
        chk({31'h0, receiver_active}, 32'h1);
        frame();
        chk({31'h0, receiver_active}, 32'h0);
        // Multi-frame at a rate above the lowest one
        xfer(1'b1, IDX_RX_MODE, 8'h14);
        xfer(1'b1, IDX_COMMAND, {4'h0, CMD_TRANSCEIVE});
        error_register <= 8'h1b;
        ck_ok <= 1'b1;
        frame();
        chk({31'h0, fifo_push}, 32'h1);
        chk({24'h0, fifo_data}, 32'h1f);
        ck_ok <= 1'b0;
        ck_err <= 1'b1;
        frame();
        chk({24'h0, fifo_data}, 32'h1b);
        settle();
        chk({31'h0, receiver_active}, 32'h1);
        xfer(1'b1, IDX_COMMAND, {4'h0, CMD_RECEIVE});
        settle();
        chk({31'h0, receiver_active}, 32'h1);
        xfer(1'b1, IDX_COMMAND, 8'h00);
        settle();
        chk({31'h0, receiver_active}, 32'h0);
        xfer(1'b1, IDX_COMMAND, {4'h0, CMD_RECEIVE});
        xfer(1'b1, IDX_RX_MODE, 8'h10);
        settle();
        chk({31'h0, receiver_active}, 32'h0);
        wrap_up();
    end
endmodule
